// ==== verilog/irp_pkg.sv ====
// Constants shared by the two-wire register port and DSP loader.
// Assumes a 10 MHz system clock and a host-driven serial clock.
package irp_pkg;
    // Target address
    localparam logic [6:0]  ADDR_LOGIC_BASE = 7'h20;
    localparam int          ADDR_ROW_SHIFT  = 3;
    localparam int          DIR_WRITE       = 0;
    // Register map, byte wide cells behind a 16-bit address
    localparam logic [15:0] CTRL_ADDR       = 16'h0000;
    localparam logic [15:0] PROG_BASE       = 16'h1000;
    localparam int          PROG_BYTES      = 3072;
    localparam logic [15:0] DATA_BASE       = 16'h2000;
    localparam int          DATA_BYTES      = 4096;
    localparam logic [15:0] PROG_LAST       = 16'h1BFF;
    localparam logic [15:0] DATA_LAST       = 16'h2FFF;
    localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;
    // Control byte layout
    localparam int          CTRL_RUN_BIT    = 0;
    localparam int          CTRL_BYPASS_BIT = 1;
    localparam int          CTRL_SIL0_BIT   = 2;
    localparam int          CTRL_SIL1_BIT   = 3;
    localparam logic [7:0]  CTRL_RESET      = 8'h01;
    // Serial frame
    localparam logic [3:0]  BIT_LAST_DATA   = 4'h7;
    localparam logic [3:0]  BIT_ACK         = 4'h8;
    // Instruction budget per sample
    localparam logic [10:0] INSTR_48K       = 11'h400;
    localparam logic [1:0]  RATE_48K        = 2'h0;
    localparam logic [1:0]  RATE_96K        = 2'h1;
    localparam logic [1:0]  RATE_192K       = 2'h2;
    // Strap capture settle time in system clocks
    localparam logic [1:0]  STRAP_SETTLE    = 2'h3;
    typedef enum {
        IRP_IDLE, IRP_ADDR, IRP_REGH, IRP_REGL, IRP_WDATA, IRP_RDATA, IRP_IGNORE
    } irp_state_t;
endpackage

// ==== verilog/irp_core.sv ====
// Two-wire register port with DSP program/data store and run control.
// Assumes SCL_IN is the host clock, SDA is open drain resolved outside,
// and that the host keeps SCL running while RESETN_IN is low.
// What this block does
// - Register addresses are sixteen bits, each selecting one byte cell.
// - Data is sampled on rising serial clock, bytes shifted most significant first.
// - Strap pins are captured once after reset, later changes ignored.
// - Logic strapping gives address 0x20 to 0x23, high pin bit 1.
// - Resistor strapping gives address eight times row index plus column index.
// - Matching address is acknowledged by pulling data low on the ninth bit.
// - Every written byte is acknowledged on its ninth rising clock edge.
// - Each further data byte goes to the previous register address plus one.
// - A stop condition ends the transaction and the port returns to idle.
// - Volatile store holds 3 kB program and 4 kB data, loaded serially.
// - After reset the read-only program runs until a loaded program restarts.
// - Audio passes unchanged when run is clear or bypass set; clear run stops core.
// - Instruction budget is 1024, 512 or 256 at 48, 96 or 192 kHz.
// - A read follows an address write and repeated start, data from that address.
// - Reads of absent addresses are acknowledged and return 0x00.
// - Read bytes continue until the host leaves the ninth bit unacknowledged.
// - A read without address write starts at last accessed address plus one.
`timescale 1ns/1ps
module irp_core (
    input  wire logic        CLK_IN,
    input  wire logic        RESETN_IN,
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE_OUT,
    input  wire logic        ADDR_STRAP_LOW_IN,
    input  wire logic        ADDR_STRAP_HIGH_IN,
    input  wire logic        STRAP_RESISTOR_MODE_IN,
    input  wire logic [2:0]  STRAP_RESISTOR_ROW_IN,
    input  wire logic [2:0]  STRAP_RESISTOR_COLUMN_IN,
    input  wire logic [1:0]  SAMPLE_RATE_SEL_IN,
    output logic [6:0]       DEV_ADDR_OUT,
    output logic             DSP_CORE_EN_OUT,
    output logic             AUDIO_PASS_OUT,
    output logic             ROM_PROG_OUT,
    output logic [1:0]       CHANNEL_SILENCE_BITS_OUT,
    output logic [10:0]      INSTR_LIMIT_OUT
);
    // System domain: pin synchronisers, strap capture
    logic [7:0]  strap_meta_reg;
    logic [7:0]  strap_sync_reg;
    logic [1:0]  settle_reg;
    logic        captured_reg;
    logic [6:0]  dev_addr_reg;
    logic [6:0]  strap_addr;
    logic [1:0]  rate_meta_reg;
    logic [1:0]  rate_sync_reg;
    // Control bits crossing from link to system domain
    logic [4:0]  ctl_meta_reg;
    logic [4:0]  ctl_sync_reg;
    logic        run_prev_reg;
    logic        rom_reg;
    logic        pass_reg;
    logic [10:0] limit_reg;
    logic        sda_low_reg;
    // Link domain
    logic [1:0]  lrst_sync_reg;
    logic [6:0]  addr_meta_reg;
    logic [6:0]  addr_link_reg;
    logic        start_tgl_reg;
    logic        stop_tgl_reg;
    logic        start_seen_reg;
    logic        stop_seen_reg;
    irp_pkg::irp_state_t state_reg;
    logic [3:0]  bit_reg;
    logic [6:0]  shift_reg;
    logic [7:0]  tx_reg;
    logic        ack_reg;
    logic        rd_dir_reg;
    logic [15:0] ptr_reg;
    logic [7:0]  ctrl_reg;
    logic        loaded_reg;
    logic        oe_reg;
    logic [7:0]  rx_byte;
    logic [7:0]  rd_byte;
    logic        lrst_n;
    logic [7:0]  prog_mem [0:irp_pkg::PROG_BYTES-1];
    logic [7:0]  data_mem [0:irp_pkg::DATA_BYTES-1];

    // Region decode, used for both read and write paths
    function automatic logic [1:0] region(input logic [15:0] a);
        if (a == irp_pkg::CTRL_ADDR) begin
            region = 2'h1;
        end else if (a >= irp_pkg::PROG_BASE && a <= irp_pkg::PROG_LAST) begin
            region = 2'h2;
        end else if (a >= irp_pkg::DATA_BASE && a <= irp_pkg::DATA_LAST) begin
            region = 2'h3;
        end else begin
            region = 2'h0;
        end
    endfunction

    // Strap and rate pins pass two flops before anything reads them
    always_ff @(posedge CLK_IN) begin
        strap_meta_reg <= {STRAP_RESISTOR_MODE_IN, ADDR_STRAP_HIGH_IN, ADDR_STRAP_LOW_IN,
                           STRAP_RESISTOR_ROW_IN[2:0], STRAP_RESISTOR_COLUMN_IN[2:1]};
        strap_sync_reg <= strap_meta_reg;
        rate_meta_reg  <= SAMPLE_RATE_SEL_IN;
        rate_sync_reg  <= rate_meta_reg;
    end

    // Column low bit is carried separately to keep the byte-wide sync bank
    logic col0_meta_reg;
    logic col0_sync_reg;
    always_ff @(posedge CLK_IN) begin
        col0_meta_reg <= STRAP_RESISTOR_COLUMN_IN[0];
        col0_sync_reg <= col0_meta_reg;
    end

    // Address from the straps: logic mode or resistor coding
    always_comb begin
        if (strap_sync_reg[7]) begin
            strap_addr = {1'b0, strap_sync_reg[4:2], strap_sync_reg[1:0], col0_sync_reg};
        end else begin
            strap_addr = irp_pkg::ADDR_LOGIC_BASE | {5'h00, strap_sync_reg[6:5]};
        end
    end

    // Capture once after reset once the synchronisers have settled
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            settle_reg   <= 2'h0;
            captured_reg <= 1'b0;
            dev_addr_reg <= 7'h00;
        end else if (!captured_reg) begin
            if (settle_reg == irp_pkg::STRAP_SETTLE) begin
                captured_reg <= 1'b1;
                dev_addr_reg <= strap_addr;
            end else begin
                settle_reg <= settle_reg + 2'h1;
            end
        end
    end

    // Control levels from the link domain, two flops each
    always_ff @(posedge CLK_IN) begin
        ctl_meta_reg <= {loaded_reg, ctrl_reg[irp_pkg::CTRL_SIL1_BIT],
                         ctrl_reg[irp_pkg::CTRL_SIL0_BIT],
                         ctrl_reg[irp_pkg::CTRL_BYPASS_BIT], ctrl_reg[irp_pkg::CTRL_RUN_BIT]};
        ctl_sync_reg <= ctl_meta_reg;
    end

    // Run control: ROM program stays selected until a loaded image is restarted
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            run_prev_reg <= 1'b1;
            rom_reg      <= 1'b1;
            pass_reg     <= 1'b0;
            sda_low_reg  <= 1'b0;
        end else begin
            run_prev_reg <= ctl_sync_reg[0];
            if (ctl_sync_reg[0] && !run_prev_reg && ctl_sync_reg[4]) begin
                rom_reg <= 1'b0;
            end
            pass_reg    <= !ctl_sync_reg[0] || ctl_sync_reg[1];
            sda_low_reg <= 1'b0;
        end
    end

    // Budget halves for each doubling of the sample rate
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            limit_reg <= irp_pkg::INSTR_48K;
        end else begin
            case (rate_sync_reg)
                irp_pkg::RATE_96K:  limit_reg <= irp_pkg::INSTR_48K >> 1;
                irp_pkg::RATE_192K: limit_reg <= irp_pkg::INSTR_48K >> 2;
                default:            limit_reg <= irp_pkg::INSTR_48K;
            endcase
        end
    end

    assign DEV_ADDR_OUT             = dev_addr_reg;
    assign DSP_CORE_EN_OUT          = ctl_sync_reg[0];
    assign AUDIO_PASS_OUT           = pass_reg;
    assign ROM_PROG_OUT             = rom_reg;
    assign CHANNEL_SILENCE_BITS_OUT = ctl_sync_reg[3:2];
    assign INSTR_LIMIT_OUT          = limit_reg;
    assign SDA_OUT                  = sda_low_reg;
    assign SDA_OE_OUT               = oe_reg;

    // Link reset and device address, both quasi-static levels into SCL domain
    always_ff @(posedge SCL_IN) begin
        lrst_sync_reg <= {lrst_sync_reg[0], RESETN_IN};
        addr_meta_reg <= dev_addr_reg;
        addr_link_reg <= addr_meta_reg;
    end
    assign lrst_n = lrst_sync_reg[1];

    // Start: SDA falls while SCL is high; the toggle is settled long before
    // the next SCL rise, which is why no extra flops sit on it
    always_ff @(negedge SDA_IN) begin
        if (!RESETN_IN) begin
            start_tgl_reg <= 1'b0;
        end else if (SCL_IN) begin
            start_tgl_reg <= !start_tgl_reg;
        end
    end

    // Stop: SDA rises while SCL is high
    always_ff @(posedge SDA_IN) begin
        if (!RESETN_IN) begin
            stop_tgl_reg <= 1'b0;
        end else if (SCL_IN) begin
            stop_tgl_reg <= !stop_tgl_reg;
        end
    end

    assign rx_byte = {shift_reg, SDA_IN};

    // Serial engine, sampling on the rising edge
    always_ff @(posedge SCL_IN) begin
        if (!lrst_n) begin
            state_reg      <= irp_pkg::IRP_IDLE;
            bit_reg        <= 4'h0;
            shift_reg      <= 7'h00;
            tx_reg         <= 8'h00;
            ack_reg        <= 1'b0;
            rd_dir_reg     <= 1'b0;
            ptr_reg        <= 16'h0000;
            ctrl_reg       <= irp_pkg::CTRL_RESET;
            loaded_reg     <= 1'b0;
            start_seen_reg <= start_tgl_reg;
            stop_seen_reg  <= stop_tgl_reg;
        end else if (start_tgl_reg != start_seen_reg) begin
            start_seen_reg <= start_tgl_reg;
            stop_seen_reg  <= stop_tgl_reg;
            state_reg      <= irp_pkg::IRP_ADDR;
            shift_reg      <= {6'h00, SDA_IN};
            bit_reg        <= 4'h1;
            ack_reg        <= 1'b0;
        end else if (stop_tgl_reg != stop_seen_reg) begin
            stop_seen_reg <= stop_tgl_reg;
            state_reg     <= irp_pkg::IRP_IDLE;
            ack_reg       <= 1'b0;
        end else if (state_reg != irp_pkg::IRP_IDLE && state_reg != irp_pkg::IRP_IGNORE) begin
            bit_reg <= (bit_reg == irp_pkg::BIT_ACK) ? 4'h0 : bit_reg + 4'h1;
            if (bit_reg < irp_pkg::BIT_LAST_DATA) begin
                shift_reg <= rx_byte[6:0];
            end else if (bit_reg == irp_pkg::BIT_LAST_DATA) begin
                ack_reg <= 1'b1;
                case (state_reg)
                    irp_pkg::IRP_ADDR: begin
                        rd_dir_reg <= rx_byte[0];
                        if (rx_byte[7:1] != addr_link_reg) begin
                            ack_reg   <= 1'b0;
                            state_reg <= irp_pkg::IRP_IGNORE;
                        end
                    end
                    irp_pkg::IRP_REGH: ptr_reg[15:8] <= rx_byte;
                    irp_pkg::IRP_REGL: ptr_reg[7:0]  <= rx_byte;
                    irp_pkg::IRP_WDATA: begin
                        case (region(ptr_reg))
                            2'h1: ctrl_reg <= rx_byte;
                            2'h2: loaded_reg <= 1'b1;
                            default: ;
                        endcase
                        ptr_reg <= ptr_reg + 16'h0001;
                    end
                    irp_pkg::IRP_RDATA: ack_reg <= 1'b0;
                    default: ack_reg <= 1'b0;
                endcase
            end else begin
                ack_reg <= 1'b0;
                case (state_reg)
                    irp_pkg::IRP_ADDR: begin
                        if (rd_dir_reg != irp_pkg::DIR_WRITE[0]) begin
                            state_reg <= irp_pkg::IRP_RDATA;
                            tx_reg    <= rd_byte;
                            ptr_reg   <= ptr_reg + 16'h0001;
                        end else begin
                            state_reg <= irp_pkg::IRP_REGH;
                        end
                    end
                    irp_pkg::IRP_REGH: state_reg <= irp_pkg::IRP_REGL;
                    irp_pkg::IRP_REGL: state_reg <= irp_pkg::IRP_WDATA;
                    irp_pkg::IRP_RDATA: begin
                        if (SDA_IN) begin
                            state_reg <= irp_pkg::IRP_IGNORE;
                        end else begin
                            tx_reg  <= rd_byte;
                            ptr_reg <= ptr_reg + 16'h0001;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Byte-wide volatile stores, written at the last data bit of a byte
    always_ff @(posedge SCL_IN) begin
        if (state_reg == irp_pkg::IRP_WDATA && bit_reg == irp_pkg::BIT_LAST_DATA
            && start_tgl_reg == start_seen_reg && stop_tgl_reg == stop_seen_reg) begin
            if (region(ptr_reg) == 2'h2) begin
                prog_mem[ptr_reg[11:0] - 12'h000] <= rx_byte;
            end
            if (region(ptr_reg) == 2'h3) begin
                data_mem[ptr_reg[11:0]] <= rx_byte;
            end
        end
    end

    // Read mux; absent cells read as zero but are still acknowledged
    always_comb begin
        case (region(ptr_reg))
            2'h1:    rd_byte = ctrl_reg;
            2'h2:    rd_byte = prog_mem[ptr_reg[11:0]];
            2'h3:    rd_byte = data_mem[ptr_reg[11:0]];
            default: rd_byte = irp_pkg::UNMAPPED_DATA;
        endcase
    end

    // Drive on the falling edge so SDA is stable across the next rise
    always_ff @(negedge SCL_IN) begin
        if (!lrst_n) begin
            oe_reg <= 1'b0;
        end else if (bit_reg == irp_pkg::BIT_ACK) begin
            oe_reg <= ack_reg;
        end else if (state_reg == irp_pkg::IRP_RDATA) begin
            oe_reg <= !tx_reg[3'h7 - bit_reg[2:0]];
        end else begin
            oe_reg <= 1'b0;
        end
    end
endmodule // irp_core

// ==== tb/irp_core_properties.sv ====
// Checker for the register port: system-side relations at the ports.
// Assumes it is bound to irp_core and sees only that module's ports.
`timescale 1ns/1ps
module irp_core_checker (
    input wire logic        CLK_IN,
    input wire logic        RESETN_IN,
    input wire logic        SDA_OUT,
    input wire logic        ADDR_STRAP_LOW_IN,
    input wire logic        ADDR_STRAP_HIGH_IN,
    input wire logic        STRAP_RESISTOR_MODE_IN,
    input wire logic [2:0]  STRAP_RESISTOR_ROW_IN,
    input wire logic [2:0]  STRAP_RESISTOR_COLUMN_IN,
    input wire logic [1:0]  SAMPLE_RATE_SEL_IN,
    input wire logic [6:0]  DEV_ADDR_OUT,
    input wire logic        DSP_CORE_EN_OUT,
    input wire logic        AUDIO_PASS_OUT,
    input wire logic        ROM_PROG_OUT,
    input wire logic [10:0] INSTR_LIMIT_OUT
);
    logic [2:0] since_reg;
    // Edges since reset release, saturating; the strap capture lands early
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) since_reg <= 3'h0;
        else if (since_reg != 3'h7) since_reg <= since_reg + 3'h1;
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    // Steady rate input, or core held stopped, long enough to pass the flops behind it
    sequence rate_steady; $stable(SAMPLE_RATE_SEL_IN) [*4]; endsequence
    sequence core_stopped; !DSP_CORE_EN_OUT [*3]; endsequence
    sda_low_only_a: assert property (SDA_OUT == 1'h0)
        else $error("data line value not low");
    pass_when_stopped_a: assert property (core_stopped |-> AUDIO_PASS_OUT)
        else $error("audio not passed with core stopped");
    limit_by_rate_a: assert property (rate_steady |-> INSTR_LIMIT_OUT ==
        ((SAMPLE_RATE_SEL_IN == 2'h1) ? 11'h200 : (SAMPLE_RATE_SEL_IN == 2'h2) ? 11'h100 : 11'h400))
        else $error("instruction limit wrong for rate");
    addr_held_a: assert property (since_reg == 3'h7 |-> $stable(DEV_ADDR_OUT))
        else $error("device address changed after capture");
    addr_logic_a: assert property (since_reg == 3'h6 && !STRAP_RESISTOR_MODE_IN |->
        DEV_ADDR_OUT == {5'h08, ADDR_STRAP_HIGH_IN, ADDR_STRAP_LOW_IN})
        else $error("logic strap address wrong");
    addr_resistor_a: assert property (since_reg == 3'h6 && STRAP_RESISTOR_MODE_IN |->
        DEV_ADDR_OUT == {1'h0, STRAP_RESISTOR_ROW_IN, STRAP_RESISTOR_COLUMN_IN})
        else $error("resistor strap address wrong");
    rom_after_reset_a: assert property ($rose(RESETN_IN) |->
        ROM_PROG_OUT && INSTR_LIMIT_OUT == 11'h400)
        else $error("read-only program not selected after reset");
    rom_stays_off_a: assert property (!ROM_PROG_OUT |=> !ROM_PROG_OUT)
        else $error("read-only program came back without reset");
endmodule // irp_core_checker

bind irp_core irp_core_checker chk (
    .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .SDA_OUT(SDA_OUT),
    .ADDR_STRAP_LOW_IN(ADDR_STRAP_LOW_IN), .ADDR_STRAP_HIGH_IN(ADDR_STRAP_HIGH_IN),
    .STRAP_RESISTOR_MODE_IN(STRAP_RESISTOR_MODE_IN),
    .STRAP_RESISTOR_ROW_IN(STRAP_RESISTOR_ROW_IN),
    .STRAP_RESISTOR_COLUMN_IN(STRAP_RESISTOR_COLUMN_IN),
    .SAMPLE_RATE_SEL_IN(SAMPLE_RATE_SEL_IN), .DEV_ADDR_OUT(DEV_ADDR_OUT),
    .DSP_CORE_EN_OUT(DSP_CORE_EN_OUT), .AUDIO_PASS_OUT(AUDIO_PASS_OUT),
    .ROM_PROG_OUT(ROM_PROG_OUT), .INSTR_LIMIT_OUT(INSTR_LIMIT_OUT));

// ==== tb/irp_host_model.sv ====
// Behavioural bus controller for the two-wire port, 125 ns serial clock.
// Assumes the bench resolves the open-drain wire with a pull-up.
`timescale 1ns/1ps
module irp_host_model (
    output logic      SCL_OUT,
    output logic      SDA_DRV_OUT,
    input  wire logic SDA_IN
);
    localparam realtime QTR = 31.25;
    // Clock stands high and data released while idle
    initial begin
        SCL_OUT = 1'h1;
        SDA_DRV_OUT = 1'h1;
    end
    // Data set while clock low, sampled at the rising edge
    task automatic xfer_bit(input logic b, output logic r);
        SDA_DRV_OUT = b;
        #QTR SCL_OUT = 1'h1;
        r = SDA_IN;
        #(2 * QTR) SCL_OUT = 1'h0;
        #QTR;
    endtask
    // Data falls while clock high, also used as repeated start
    task automatic start_cond();
        SDA_DRV_OUT = 1'h1;
        #QTR SCL_OUT = 1'h1;
        #QTR SDA_DRV_OUT = 1'h0;
        #QTR SCL_OUT = 1'h0;
        #QTR;
    endtask
    // Data rises while clock high; clock then stands still
    task automatic stop_cond();
        SDA_DRV_OUT = 1'h0;
        #QTR SCL_OUT = 1'h1;
        #QTR SDA_DRV_OUT = 1'h1;
        #QTR;
    endtask
    // Idle clocks with data released, lets the link reset drain
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #(2 * QTR) SCL_OUT = 1'h0;
            #(2 * QTR) SCL_OUT = 1'h1;
        end
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(b[i], r);
        xfer_bit(1'h1, r);
        ack = !r;
    endtask
    // Last byte of a read is left unacknowledged before the stop
    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'h1, r);
            b[i] = r;
        end
        xfer_bit(nack, r);
    endtask
endmodule // irp_host_model

// ==== tb/irp_core_tb_top.sv ====
// Self-checking bench: serial transfers, strap capture and control outputs.
// Assumes irp_core, its package, the checker and the host model compiled first.
`timescale 1ns/1ps
module irp_core_tb_top;
    logic        clk = 1'h0, rstn = 1'h0, s_low = 1'h0, s_high = 1'h1, s_mode = 1'h0;
    logic [2:0]  s_row = 3'h5, s_col = 3'h3;
    logic [1:0]  rate = 2'h0;
    logic [6:0]  dev = 7'h22;
    wire         scl, host_sda, dut_sda, dut_oe, core_en, pass, rom;
    wire  [6:0]  dev_addr;
    wire  [1:0]  silence;
    wire  [10:0] limit;
    int          fail_count = 0, comparisons = 0;
    // Open-drain wire with pull-up: low if either party pulls
    wire         sda_wire = host_sda & ~(dut_oe & ~dut_sda);
    always #50 clk = ~clk;
    irp_host_model host (.SCL_OUT(scl), .SDA_DRV_OUT(host_sda), .SDA_IN(sda_wire));
    irp_core dut (.CLK_IN(clk), .RESETN_IN(rstn), .SCL_IN(scl), .SDA_IN(sda_wire),
        .SDA_OUT(dut_sda), .SDA_OE_OUT(dut_oe), .ADDR_STRAP_LOW_IN(s_low),
        .ADDR_STRAP_HIGH_IN(s_high), .STRAP_RESISTOR_MODE_IN(s_mode),
        .STRAP_RESISTOR_ROW_IN(s_row), .STRAP_RESISTOR_COLUMN_IN(s_col),
        .SAMPLE_RATE_SEL_IN(rate), .DEV_ADDR_OUT(dev_addr), .DSP_CORE_EN_OUT(core_en),
        .AUDIO_PASS_OUT(pass), .ROM_PROG_OUT(rom), .CHANNEL_SILENCE_BITS_OUT(silence),
        .INSTR_LIMIT_OUT(limit));
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One byte out, acknowledge expected on its ninth clock
    task automatic snd(input logic [7:0] b);
        logic ack;
        host.send_byte(b, ack);
        check("ack", 16'h0001, 16'(ack));
    endtask
    // Upper then lower address byte, then n ascending data bytes
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n);
        host.start_cond();
        snd({dev, 1'h0});
        snd(a[15:8]);
        snd(a[7:0]);
        for (int i = 0; i < n; i++) snd(d + 8'(i));
        host.stop_cond();
    endtask
    task automatic rd(input logic [15:0] a, input logic use_a, input logic [7:0] e, input int n);
        logic [7:0] got;
        host.start_cond();
        if (use_a) begin
            snd({dev, 1'h0});
            snd(a[15:8]);
            snd(a[7:0]);
            host.start_cond();
        end
        snd({dev, 1'h1});
        for (int i = 0; i < n; i++) begin
            host.recv_byte(i == n - 1, got);
            check("read data", 16'(e + 8'(i)), 16'(got));
        end
        host.stop_cond();
    endtask
    // Reset with two start and stop pairs inside, then drain the link reset
    task automatic do_reset();
        @(negedge clk) rstn = 1'h0;
        host.start_cond();
        host.stop_cond();
        host.start_cond();
        host.stop_cond();
        // Link reset needs three serial clock rises while reset is still low
        host.idle_clocks(3);
        repeat (20) @(negedge clk);
        rstn = 1'h1;
        host.idle_clocks(3);
        repeat (12) @(negedge clk);
    endtask
    // A hang ends the run through the same verdict
    initial begin
        #2000000;
        fail_count++;
        give_verdict();
    end
    initial begin
        logic ack;
        do_reset();
        check("dev addr", 16'h0022, 16'(dev_addr));
        check("rom prog", 16'h0001, 16'(rom));
        @(negedge clk) s_high = 1'h0;
        s_low = 1'h1;
        repeat (5) @(negedge clk);
        check("dev addr held", 16'h0022, 16'(dev_addr));
        host.start_cond();
        host.send_byte(8'h42, ack);
        check("foreign ack", 16'h0000, 16'(ack));
        host.send_byte(8'h00, ack);
        check("ignored ack", 16'h0000, 16'(ack));
        host.stop_cond();
        wr(16'h0000, 8'h0C, 1);
        repeat (10) @(negedge clk);
        check("core en", 16'h0000, 16'(core_en));
        check("pass", 16'h0001, 16'(pass));
        check("silence", 16'h0003, 16'(silence));
        wr(16'h1BFE, 8'hA5, 2);
        rd(16'h1BFE, 1'h1, 8'hA5, 1);
        rd(16'h0000, 1'h0, 8'hA6, 1);
        rd(16'h1BFE, 1'h1, 8'hA5, 2);
        rd(16'h3000, 1'h1, 8'h00, 1);
        wr(16'h2FFF, 8'h3C, 1);
        rd(16'h2FFF, 1'h1, 8'h3C, 1);
        wr(16'h0000, 8'h0D, 1);
        repeat (10) @(negedge clk);
        check("rom after load", 16'h0000, 16'(rom));
        check("pass running", 16'h0000, 16'(pass));
        wr(16'h0000, 8'h03, 1);
        repeat (10) @(negedge clk);
        check("pass bypass", 16'h0001, 16'(pass));
        check("unsilenced", 16'h0000, 16'(silence));
        for (int i = 0; i < 4; i++) begin
            @(negedge clk) rate = 2'(i);
            repeat (6) @(negedge clk);
            check("limit", (i == 1) ? 16'h0200 : (i == 2) ? 16'h0100 : 16'h0400, 16'(limit));
        end
        @(negedge clk) rate = 2'h0;
        s_mode = 1'h1;
        dev = 7'h2B;
        do_reset();
        check("resistor addr", 16'h002B, 16'(dev_addr));
        check("rom again", 16'h0001, 16'(rom));
        rd(16'h0000, 1'h1, 8'h01, 1);
        give_verdict();
    end
endmodule // irp_core_tb_top
